// File: hw/edge_detect_pkg.sv
// Shared constants for the external pin edge detector.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus with 32-bit data.
package edge_detect_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [15:0] IDX_NOISE_SEL = 16'hff3b;
	localparam logic [15:0] IDX_SEL_LOW = 16'hff3c;
	localparam logic [15:0] IDX_SEL_HIGH = 16'hff3d;
	localparam logic [15:0] IDX_FLAGS_LOWER = 16'hff3e;
	localparam logic [15:0] IDX_FLAGS_UPPER = 16'hff3f;
	localparam logic [31:0] ADDR_NOISE_SEL = {14'h0000, IDX_NOISE_SEL, 2'h0};
	localparam logic [31:0] ADDR_SEL_LOW = {14'h0000, IDX_SEL_LOW, 2'h0};
	localparam logic [31:0] ADDR_SEL_HIGH = {14'h0000, IDX_SEL_HIGH, 2'h0};
	localparam logic [31:0] ADDR_FLAGS_LOWER = {14'h0000, IDX_FLAGS_LOWER, 2'h0};
	localparam logic [31:0] ADDR_FLAGS_UPPER = {14'h0000, IDX_FLAGS_UPPER, 2'h0};

	// Reset values and fixed-zero masks
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [6:0] NOISE_RESET = 7'h00;
	localparam logic [13:0] FLAGS_RESET = 14'h0000;
	localparam logic [7:0] SEL_LOW_WMASK = 8'hfd;

	// Two-bit edge field codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Noise filter: a level is taken on the fourth identical sample
	localparam logic [1:0] RUN_LAST = 2'h3;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam int CLK_PERIOD_NS = 10;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

// File: hw/edge_detector.sv
// Edge detector for eight external inputs with AHB-Lite register access.
// Assumes edge inputs are asynchronous pins, standby mode levels come from the
// power controller on the same clock, and the bus master issues single word transfers.
`timescale 1ns/1ps
module edge_detector (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] edge_input,
	input wire logic stop_mode,
	input wire logic idle_mode,
	output logic nmi_request,
	output logic standby_release,
	output logic [6:0] external_interrupt_request,
	output logic timer0_capture_ch0,
	output logic timer0_capture_ch1,
	output logic timer0_capture_ch2,
	output logic timer0_capture_ch3,
	output logic adc_conversion_start,
	output logic timer2_count_clock,
	output logic timer3_count_clock
);
	logic [7:0] edge_select_low_group;
	logic [7:0] edge_select_high_group;
	logic [6:0] noise_sampling_select;
	logic [13:0] edge_flags;
	logic [31:0] read_data;
	logic ready;
	logic wr_pend;
	logic [31:0] wr_addr;
	logic [7:0] meta;
	logic [7:0] sync;
	logic [7:0] level;
	logic [7:0] level_prev;
	logic [1:0] run [7:1];
	logic [1:0] div4_count;
	logic div4_en;
	logic [7:0] suppress;
	logic [7:0] pulse;

	// Bus decode
	wire addr_phase = hsel && hready && (htrans == edge_detect_pkg::HTRANS_NONSEQ);
	wire take_read = addr_phase && !hwrite;
	wire take_write = addr_phase && hwrite;
	wire wr_sel_low = wr_pend && (wr_addr == edge_detect_pkg::ADDR_SEL_LOW);
	wire wr_sel_high = wr_pend && (wr_addr == edge_detect_pkg::ADDR_SEL_HIGH);
	wire wr_noise = wr_pend && (wr_addr == edge_detect_pkg::ADDR_NOISE_SEL);
	wire wr_flags_lower = wr_pend && (wr_addr == edge_detect_pkg::ADDR_FLAGS_LOWER);
	wire wr_flags_upper = wr_pend && (wr_addr == edge_detect_pkg::ADDR_FLAGS_UPPER);

	// Bit 1 of the low select register is held at zero
	wire [7:0] next_sel_low = wr_sel_low ? (hwdata[7:0] & edge_detect_pkg::SEL_LOW_WMASK)
		: edge_select_low_group;
	wire [7:0] next_sel_high = wr_sel_high ? hwdata[7:0] : edge_select_high_group;
	wire [15:0] sel_all = {edge_select_high_group, edge_select_low_group};
	wire [15:0] next_sel_all = {next_sel_high, next_sel_low};

	// Read mux; software does bit operations as read-modify-write of a whole word
	logic [31:0] next_read_data;
	always_comb begin
		next_read_data = 32'h00000000;
		case (haddr)
			edge_detect_pkg::ADDR_NOISE_SEL: next_read_data = {25'h0000000, noise_sampling_select};
			edge_detect_pkg::ADDR_SEL_LOW: next_read_data = {24'h000000, edge_select_low_group};
			edge_detect_pkg::ADDR_SEL_HIGH: next_read_data = {24'h000000, edge_select_high_group};
			edge_detect_pkg::ADDR_FLAGS_LOWER: next_read_data = {24'h000000, edge_flags[7:0]};
			edge_detect_pkg::ADDR_FLAGS_UPPER: next_read_data = {26'h0000000, edge_flags[13:8]};
			default: next_read_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h00000000;
			read_data <= 32'h00000000;
			ready <= 1'b1;
		end else begin
			wr_pend <= take_write;
			if (take_write)
				wr_addr <= haddr;
			if (take_read)
				read_data <= next_read_data;
			ready <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			edge_select_low_group <= edge_detect_pkg::SEL_RESET;
			edge_select_high_group <= edge_detect_pkg::SEL_RESET;
			noise_sampling_select <= edge_detect_pkg::NOISE_RESET;
		end else begin
			edge_select_low_group <= next_sel_low;
			edge_select_high_group <= next_sel_high;
			if (wr_noise)
				noise_sampling_select <= hwdata[6:0];
		end
	end

	// Two-flop synchroniser for the pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta <= 8'h00;
			sync <= 8'h00;
		end else begin
			meta <= edge_input;
			sync <= meta;
		end
	end

	// Divide-by-four sampling enable
	always_ff @(posedge clock) begin
		if (!rst_n)
			div4_count <= 2'h0;
		else
			div4_count <= div4_count + 2'h1;
	end
	assign div4_en = (div4_count == edge_detect_pkg::DIV4_LAST);

	// Inputs 1-7 freeze in stop and idle; input 0 has its own delay outside and runs on
	wire standby = stop_mode || idle_mode;
	logic [7:1] sample_en;
	always_comb begin
		for (int i = 1; i < 8; i++)
			sample_en[i] = !standby && (noise_sampling_select[i-1] ? div4_en : 1'b1);
	end

	// Level starts low, so an input high at release shows up as a rising edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			level <= 8'h00;
			level_prev <= 8'h00;
			for (int i = 1; i < 8; i++)
				run[i] <= 2'h0;
		end else begin
			level[0] <= sync[0];
			level_prev <= level;
			for (int i = 1; i < 8; i++) begin
				if (sample_en[i]) begin
					if (sync[i] == level[i]) begin
						run[i] <= 2'h0;
					end else if (run[i] == edge_detect_pkg::RUN_LAST) begin
						level[i] <= sync[i];
						run[i] <= 2'h0;
					end else begin
						run[i] <= run[i] + 2'h1;
					end
				end
			end
		end
	end

	wire [7:0] rise_evt = level & ~level_prev;
	wire [7:0] fall_evt = ~level & level_prev;

	// Per-input decode; code 10 enables neither edge
	logic [7:0] rise_en;
	logic [7:0] fall_en;
	logic [7:0] sel_change;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			rise_en[i] = (sel_all[2*i +: 2] == edge_detect_pkg::EDGE_RISE)
				|| (sel_all[2*i +: 2] == edge_detect_pkg::EDGE_BOTH);
			fall_en[i] = (sel_all[2*i +: 2] == edge_detect_pkg::EDGE_FALL)
				|| (sel_all[2*i +: 2] == edge_detect_pkg::EDGE_BOTH);
			sel_change[i] = (next_sel_all[2*i +: 2] != sel_all[2*i +: 2]);
		end
	end

	// Detection is masked in the write cycle and the one after it
	wire [7:0] blocked = sel_change | suppress;
	wire [7:0] next_pulse = ~blocked & ((rise_evt & rise_en) | (fall_evt & fall_en));

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			suppress <= 8'h00;
			pulse <= 8'h00;
		end else begin
			suppress <= sel_change;
			pulse <= next_pulse;
		end
	end

	// Flags see every filtered edge, whatever the selection; a hardware set beats a clear
	logic [13:0] hw_set;
	always_comb begin
		hw_set = 14'h0000;
		for (int i = 1; i < 8; i++) begin
			hw_set[2*(i-1)] = fall_evt[i];
			hw_set[2*(i-1)+1] = rise_evt[i];
		end
	end
	wire [13:0] wr_flag_mask = {{6{wr_flags_upper}}, {8{wr_flags_lower}}};
	wire [13:0] wr_flag_data = {hwdata[5:0], hwdata[7:0]};
	wire [13:0] next_flags = hw_set | ((wr_flag_mask & wr_flag_data) | (~wr_flag_mask & edge_flags));

	// Contents after reset are not promised; zero is loaded here
	always_ff @(posedge clock) begin
		if (!rst_n)
			edge_flags <= edge_detect_pkg::FLAGS_RESET;
		else
			edge_flags <= next_flags;
	end

	assign hrdata = read_data;
	assign hreadyout = ready;
	assign hresp = edge_detect_pkg::HRESP_OKAY;
	assign nmi_request = pulse[0];
	assign standby_release = pulse[0];
	assign external_interrupt_request = pulse[7:1];
	assign timer0_capture_ch0 = pulse[1];
	assign timer0_capture_ch1 = pulse[2];
	assign timer0_capture_ch2 = pulse[3];
	assign timer0_capture_ch3 = pulse[4];
	assign adc_conversion_start = pulse[5];
	assign timer2_count_clock = pulse[6];
	assign timer3_count_clock = pulse[7];

	default clocking main_cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence read_upper_s;
		take_read && (haddr == edge_detect_pkg::ADDR_FLAGS_UPPER) ##1 1'b1;
	endsequence

	sequence sel_write_change_s;
		wr_pend && (sel_change != 8'h00);
	endsequence

	sequence four_equal_s;
		sample_en[1] && !noise_sampling_select[0] && (sync[1] != level[1]) [*4];
	endsequence

	mode_reset_clear_a: assert property ($rose(rst_n) |-> (sel_all == 16'h0000))
		else $error("select registers not cleared by reset");

	nmi_bit_zero_a: assert property (edge_select_low_group[1] == 1'b0)
		else $error("low select bit 1 not zero");

	rise_flag_set_a: assert property ((rise_evt[7:1] != 7'h00)
		|=> ((edge_flags[13:8] | edge_flags[7:0]) != 8'h00))
		else $error("rising edge left no flag");

	flag_hold_a: assert property ((edge_flags & ~next_flags) != 14'h0000
		|-> (wr_flags_lower || wr_flags_upper))
		else $error("flag dropped without a write");

	set_beats_clear_a: assert property ((wr_flags_lower && fall_evt[1])
		|=> edge_flags[0])
		else $error("clear overrode a simultaneous set");

	upper_high_zero_a: assert property (read_upper_s |-> (hrdata[31:6] == 26'h0000000))
		else $error("upper flag register high bits not zero");

	change_suppress_a: assert property (sel_write_change_s |=> ((pulse & $past(sel_change)) == 8'h00)
		##1 ((pulse & $past(sel_change, 2)) == 8'h00))
		else $error("pulse during selection change");

	pulse_select_a: assert property (next_pulse[1] |-> ((rise_evt[1] && rise_en[1])
		|| (fall_evt[1] && fall_en[1])))
		else $error("capture pulse without selected edge");

	pulse_one_cycle_a: assert property ($rose(pulse[1]) |-> ##1 !pulse[1])
		else $error("detection pulse longer than one clock");

	standby_freeze_a: assert property (standby && $past(standby) |-> (rise_evt[7:1] == 7'h00)
		&& (fall_evt[7:1] == 7'h00))
		else $error("edge on inputs 1-7 during standby");

	filter_four_a: assert property (four_equal_s |=> (level[1] == $past(sync[1])))
		else $error("level not taken after four samples");

	filter_short_a: assert property ($changed(level[1]) |-> $past(run[1]) == edge_detect_pkg::RUN_LAST)
		else $error("level changed before four samples");

	div4_period_a: assert property (div4_en |=> !div4_en [*3] ##1 div4_en)
		else $error("divide-by-four enable out of step");

	// Input 1 stands in for the other filtered inputs in the per-input checks
	nmi_pulse_edge_a: assert property (next_pulse[0] |-> ((rise_evt[0] && edge_select_low_group[0])
		|| (fall_evt[0] && !edge_select_low_group[0])))
		else $error("input 0 pulse on the wrong polarity");

	code_ten_quiet_a: assert property ((sel_all[3:2] != edge_detect_pkg::EDGE_FALL)
		&& (sel_all[3:2] != edge_detect_pkg::EDGE_RISE) && (sel_all[3:2] != edge_detect_pkg::EDGE_BOTH)
		|-> !next_pulse[1])
		else $error("prohibited code produced a pulse");

	fall_flag_set_a: assert property (fall_evt[1] |=> edge_flags[0])
		else $error("falling edge of input 1 left no flag");

	rise_flag_one_a: assert property (rise_evt[1] |=> edge_flags[1])
		else $error("rising edge of input 1 left no flag");

	nmi_standby_runs_a: assert property (standby && (sync[0] != level[0])
		|=> (level[0] == $past(sync[0])))
		else $error("input 0 stalled in standby");

	upper_read_data_a: assert property (read_upper_s |-> (hrdata[5:0] == $past(edge_flags[13:8])))
		else $error("upper flag register read wrong data");

	low_sel_write_a: assert property (wr_sel_low
		|=> (edge_select_low_group == ($past(hwdata[7:0]) & edge_detect_pkg::SEL_LOW_WMASK)))
		else $error("low select register missed a write");

	high_sel_write_a: assert property (wr_sel_high |=> (edge_select_high_group == $past(hwdata[7:0])))
		else $error("high select register missed a write");

	noise_sel_write_a: assert property (wr_noise |=> (noise_sampling_select == $past(hwdata[6:0])))
		else $error("noise select register missed a write");
endmodule

// File: verif/edge_source.sv
// Behavioural model of the signal sources on the eight edge pins.
// Assumes the bench changes target levels just after a rising clock edge.
`timescale 1ns/1ps
module edge_source (
	input wire logic clock,
	input wire logic slow,
	input wire logic [7:0] target,
	output logic [7:0] pins
);
	logic [7:0] near_q = 8'h00;
	logic [7:0] far_q = 8'h00;

	// Slow sources answer one cycle after fast ones but keep every pulse width intact
	always @(posedge clock) begin
		near_q <= target;
		far_q <= near_q;
	end

	assign pins = slow ? far_q : near_q;
endmodule

// File: verif/test_edge_detector.sv
// Self-checking bench for the edge detector: AHB-Lite register tasks plus pin pulses.
// Assumes the slave answers with zero wait states and pins reach pulses within about 21 clocks.
`timescale 1ns/1ps
module test_edge_detector;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic stop_mode = 1'b0;
	logic idle_mode = 1'b0;
	logic slow = 1'b0;
	logic [7:0] target = 8'h08;
	wire [7:0] pins;
	wire hready;
	wire hresp;
	wire [31:0] hrdata;
	wire [15:0] pv;
	int pcnt [16] = '{default: 0};
	int base [16] = '{default: 0};
	int bad_count = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic [1:0] codes [4] = '{edge_detect_pkg::EDGE_FALL, edge_detect_pkg::EDGE_RISE, edge_detect_pkg::EDGE_BOTH, 2'h2};
	int npulse [4] = '{1, 1, 2, 0};
	int wid [4] = '{3, 5, 8, 24};

	always #5 clock = ~clock;

	edge_source u_src (.clock(clock), .slow(slow), .target(target), .pins(pins));

	edge_detector u_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .edge_input(pins), .stop_mode(stop_mode), .idle_mode(idle_mode), .nmi_request(pv[0]),
		.standby_release(pv[15]), .external_interrupt_request(pv[7:1]), .timer0_capture_ch0(pv[8]),
		.timer0_capture_ch1(pv[9]), .timer0_capture_ch2(pv[10]), .timer0_capture_ch3(pv[11]),
		.adc_conversion_start(pv[12]), .timer2_count_clock(pv[13]), .timer3_count_clock(pv[14]));

	// Pulse outputs stand one cycle, so every clock is counted
	always @(posedge clock) begin
		for (int j = 0; j < 16; j++) begin
			pcnt[j] <= pcnt[j] + int'(pv[j]);
		end
	end

	function automatic logic [31:0] delta(input int j);
		return 32'(pcnt[j] - base[j]);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= edge_detect_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check(rd, exp);
	endtask

	// The long low tail lets even the divided sampling clock settle the filter
	task automatic pulse_pin(input int i, input int w);
		@(posedge clock);
		if (w > 0) begin
			target[i] <= 1'b1;
			repeat (w) @(posedge clock);
		end
		target[i] <= 1'b0;
		repeat (40) @(posedge clock);
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		test_done();
	end

	initial begin
		int sh;
		int fb;
		logic [31:0] fl;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		repeat (12) @(posedge clock);
		rchk(edge_detect_pkg::ADDR_SEL_LOW, 32'h0);
		rchk(edge_detect_pkg::ADDR_SEL_HIGH, 32'h0);
		rchk(edge_detect_pkg::ADDR_FLAGS_LOWER, 32'h20);
		base = pcnt;
		pulse_pin(3, 0);
		check(delta(3), 32'h1);
		rchk(edge_detect_pkg::ADDR_FLAGS_LOWER, 32'h30);
		bus(edge_detect_pkg::ADDR_FLAGS_LOWER, 1'b1, 32'h0);
		rchk(edge_detect_pkg::ADDR_FLAGS_LOWER, 32'h0);
		rchk(32'h0, 32'h0);
		bus(edge_detect_pkg::ADDR_SEL_LOW, 1'b1, 32'hff);
		rchk(edge_detect_pkg::ADDR_SEL_LOW, 32'hfd);
		bus(edge_detect_pkg::ADDR_SEL_LOW, 1'b1, 32'h01);
		base = pcnt;
		pulse_pin(0, 6);
		check(delta(0), 32'h1);
		check(delta(15), 32'h1);
		for (int k = 1; k < 8; k++) begin
			foreach (codes[c]) begin
				sh = (k < 4) ? 2 * k : 2 * (k - 4);
				fb = (k < 5) ? 2 * (k - 1) : 2 * (k - 5);
				fl = (k < 5) ? edge_detect_pkg::ADDR_FLAGS_LOWER : edge_detect_pkg::ADDR_FLAGS_UPPER;
				slow <= k[0];
				bus((k < 4) ? edge_detect_pkg::ADDR_SEL_LOW : edge_detect_pkg::ADDR_SEL_HIGH, 1'b1, 32'(codes[c]) << sh);
				base = pcnt;
				pulse_pin(k, 6);
				check(delta(k), 32'(npulse[c]));
				check(delta(k + 7), 32'(npulse[c]));
				rchk(fl, 32'h3 << fb);
				bus(fl, 1'b1, 32'h0);
			end
		end
		bus(edge_detect_pkg::ADDR_SEL_LOW, 1'b1, 32'h30);
		for (int n = 0; n < 4; n++) begin
			bus(edge_detect_pkg::ADDR_NOISE_SEL, 1'b1, (n > 1) ? 32'h2 : 32'h0);
			base = pcnt;
			pulse_pin(2, wid[n]);
			check(delta(2), (n % 2 == 1) ? 32'h2 : 32'h0);
		end
		bus(edge_detect_pkg::ADDR_NOISE_SEL, 1'b1, 32'h0);
		bus(edge_detect_pkg::ADDR_SEL_LOW, 1'b1, 32'h31);
		bus(edge_detect_pkg::ADDR_FLAGS_LOWER, 1'b1, 32'h0);
		for (int m = 0; m < 2; m++) begin
			stop_mode <= (m == 0);
			idle_mode <= (m == 1);
			base = pcnt;
			pulse_pin(2, 6);
			pulse_pin(0, 6);
			check(delta(2), 32'h0);
			check(delta(0), 32'h1);
			rchk(edge_detect_pkg::ADDR_FLAGS_LOWER, 32'h0);
		end
		stop_mode <= 1'b0;
		idle_mode <= 1'b0;
		slow <= 1'b0;
		@(posedge clock);
		target[1] <= 1'b1;
		repeat (20) @(posedge clock);
		target[1] <= 1'b0;
		// Timed so the clear's data phase meets the filtered falling edge of input 1
		repeat (5) @(posedge clock);
		bus(edge_detect_pkg::ADDR_FLAGS_LOWER, 1'b1, 32'h0);
		rchk(edge_detect_pkg::ADDR_FLAGS_LOWER, 32'h1);
		bus(edge_detect_pkg::ADDR_SEL_LOW, 1'b1, 32'h0);
		base = pcnt;
		pulse_pin(0, 6);
		check(delta(0), 32'h1);
		bus(edge_detect_pkg::ADDR_FLAGS_UPPER, 1'b1, 32'hff);
		rchk(edge_detect_pkg::ADDR_FLAGS_UPPER, 32'h3f);
		test_done();
	end
endmodule
